// ==== smm_device.sv ====
`timescale 1ns/1ps
`include "smm_defines.svh"
module smm_device #(
  parameter int LATCH_UNIT_CYC = `SMM_LATCH_UNIT_MS * 1000000 / `SMM_CLK_NS
) (
  input logic CORE_CLK,
  input logic SYS_RST,
  smm_spi_if.dev spi,
  input logic [`SMM_NCHAN-1:0] CURRENT_FLAG,
  input logic [`SMM_NGATE-1:0] FIRE_GATE_INPUT,
  input logic [2*`SMM_NGATE-1:0] LATCH_SEL,
  output logic [`SMM_NGATE-1:0] FIRE_GATE
);
  localparam logic [`SMM_TICK_W-1:0] TICK_LAST = `SMM_TICK_W'(`SMM_TICK_CYC - 1);
  localparam logic [`SMM_HI_W-1:0] HI_MIN = `SMM_HI_W'(`SMM_MIN_HI_CYC);
  localparam logic [`SMM_LATCH_W-1:0] UNIT1 = `SMM_LATCH_W'(LATCH_UNIT_CYC);
  localparam logic [`SMM_LATCH_W-1:0] UNIT2 = `SMM_LATCH_W'(2 * LATCH_UNIT_CYC);
  localparam logic [`SMM_LATCH_W-1:0] UNIT4 = `SMM_LATCH_W'(4 * LATCH_UNIT_CYC);

  smm_pkg::smm_dev_t s_r;
  smm_pkg::smm_dev_t s_nxt;
  logic [`SMM_W-1:0] resp;
  logic [7:0] status_bits;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic tick_hit;
  logic cmd_ok;
  logic [2:0] cmd_chan;

  // Latch length for the programmed code 0, 1, 2, 3
  function automatic logic [`SMM_LATCH_W-1:0] latch_len(input logic [1:0] sel);
    logic [`SMM_LATCH_W-1:0] len;
    case (sel)
      2'h0: len = '0;
      2'h1: len = UNIT1;
      2'h2: len = UNIT2;
      default: len = UNIT4;
    endcase
    return len;
  endfunction : latch_len

  always_comb begin
    s_nxt = s_r;
    resp = `SMM_IDLE_RESP;
    status_bits = 8'h00;
    rise = spi.sclk & ~s_r.sclk_q;
    fall = ~spi.sclk & s_r.sclk_q;
    cs_fall = ~spi.cs_n & s_r.cs_q;
    cs_rise = spi.cs_n & ~s_r.cs_q;
    tick_hit = (s_r.tick == TICK_LAST);
    cmd_ok = 1'b0;
    cmd_chan = s_r.shin[`SMM_CHAN_HI:`SMM_CHAN_LO];
    s_nxt.sclk_q = spi.sclk;
    s_nxt.cs_q = spi.cs_n;

    // Duration time base, one step per 25 us
    if (tick_hit) begin
      s_nxt.tick = '0;
    end else begin
      s_nxt.tick = s_r.tick + `SMM_TICK_W'(1);
    end

    // Per-channel duration while current is above threshold
    for (int c = 0; c < `SMM_NCHAN; c++) begin
      if (CURRENT_FLAG[c] && !s_r.cur_prev[c]) begin
        s_nxt.dur[c] = '0;
      end else if (CURRENT_FLAG[c] && tick_hit && (s_r.dur[c] != '1)) begin
        s_nxt.dur[c] = s_r.dur[c] + `SMM_DUR_W'(1);
      end
    end
    s_nxt.cur_prev = CURRENT_FLAG;

    // Fire gate high-time check and latch timers
    for (int g = 0; g < `SMM_NGATE; g++) begin
      if (FIRE_GATE_INPUT[g]) begin
        if (s_r.hi_cnt[g] != HI_MIN) begin
          s_nxt.hi_cnt[g] = s_r.hi_cnt[g] + `SMM_HI_W'(1);
        end
      end else begin
        s_nxt.hi_cnt[g] = '0;
      end
      if (s_r.gin_q[g] && !FIRE_GATE_INPUT[g] && (s_r.hi_cnt[g] >= HI_MIN)) begin
        s_nxt.latch[g] = latch_len(LATCH_SEL[2*g +: 2]);
      end else if (s_r.latch[g] != '0) begin
        s_nxt.latch[g] = s_r.latch[g] - `SMM_LATCH_W'(1);
      end
      s_nxt.gate[g] = FIRE_GATE_INPUT[g] | (s_nxt.latch[g] != '0);
    end
    s_nxt.gin_q = FIRE_GATE_INPUT;

    // Frame start: build the answer to the last accepted command
    if (cs_fall) begin
      s_nxt.bitcnt = '0;
      if (s_r.type_sel) begin
        status_bits = {4'h0, s_r.gate};
      end else begin
        status_bits = CURRENT_FLAG;
      end
      case (s_r.kind)
        smm_pkg::SMM_KIND_MON2: begin
          resp = `SMM_MON2_CODE | {6'h00, s_r.chan, s_r.dur[s_r.chan]};
        end
        smm_pkg::SMM_KIND_MON3: begin
          resp = `SMM_MON3_CODE | {6'h00, s_r.type_sel, s_r.por_flag, status_bits};
          s_nxt.por_flag = 1'b1;
        end
        default: begin
          resp = `SMM_IDLE_RESP;
        end
      endcase
      resp[`SMM_PAR_BIT] = ~^resp;
      s_nxt.shout = resp;
      s_nxt.miso = resp[`SMM_W-1];
    end else if (!spi.cs_n) begin
      if (rise) begin
        s_nxt.shin = {s_r.shin[`SMM_W-2:0], spi.mosi};
        if (s_r.bitcnt != '1) begin
          s_nxt.bitcnt = s_r.bitcnt + 5'h01;
        end
      end
      if (fall) begin
        s_nxt.shout = {s_r.shout[`SMM_W-2:0], 1'b0};
        s_nxt.miso = s_r.shout[`SMM_W-2];
      end
    end

    // Frame end: decode only full frames with odd parity
    if (cs_rise && (s_r.bitcnt == `SMM_BITS_FULL)) begin
      cmd_ok = ^s_r.shin;
    end
    if (cmd_ok) begin
      if ((s_r.shin & `SMM_MON2_MASK) == `SMM_MON2_CODE) begin
        s_nxt.kind = smm_pkg::SMM_KIND_MON2;
        s_nxt.chan = cmd_chan;
        if (s_r.shin[`SMM_CLEAR_BIT]) begin
          s_nxt.dur[cmd_chan] = '0;
        end
      end else if ((s_r.shin & `SMM_MON3_MASK) == `SMM_MON3_CODE) begin
        s_nxt.kind = smm_pkg::SMM_KIND_MON3;
        s_nxt.type_sel = s_r.shin[`SMM_TYPE_BIT];
      end else begin
        s_nxt.kind = smm_pkg::SMM_KIND_NONE;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s_r <= '0;
      s_r.cs_q <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign spi.miso = s_r.miso;
  assign FIRE_GATE = s_r.gate;
endmodule : smm_device

// ==== smm_defines.svh ====
// Summary of operation
// - Master sends mode 2 request code
// - Bit 13 makes every word odd parity
// - Clear bit zeroes selected channel duration
// - Bits 9..7 select channel, binary
// - Mode 2 response echoes stored channel
// - Mode 2 low bits carry duration count
// - Mode 2 response header, bit 12 zero
// - Master sends mode 3 request code
// - Selector picks current or gate status
// - Mode 3 response carries reset flag
// - Gate status is pin OR latch
// - Current flags in bits 7..0
// - Reset flag reads 0, then 1
// - Gate status bits 3..0, upper zero
// - Current flags sampled at select fall
// - Latch starts after 16 us high pulse
`ifndef SMM_DEFINES_SVH
`define SMM_DEFINES_SVH
`define SMM_W 16
`define SMM_PAR_BIT 13
`define SMM_CLEAR_BIT 12
`define SMM_CHAN_HI 9
`define SMM_CHAN_LO 7
`define SMM_TYPE_BIT 9
`define SMM_MON2_MASK 16'hCC00
`define SMM_MON2_CODE 16'hC400
`define SMM_MON3_MASK 16'hDC00
`define SMM_MON3_CODE 16'hC800
`define SMM_IDLE_RESP 16'h0000
`define SMM_NCHAN 8
`define SMM_NGATE 4
`define SMM_DUR_W 7
`define SMM_CLK_NS 20
`define SMM_TICK_NS 25000
`define SMM_TICK_CYC ((`SMM_TICK_NS) / (`SMM_CLK_NS))
`define SMM_TICK_W 11
`define SMM_MIN_HI_NS 16000
`define SMM_MIN_HI_CYC ((`SMM_MIN_HI_NS + `SMM_CLK_NS - 1) / `SMM_CLK_NS)
`define SMM_HI_W 10
`define SMM_LATCH_UNIT_MS 128
`define SMM_LATCH_W 25
`define SMM_BITS_FULL 5'h10
`define SMM_HALF_DEF 5
`define SMM_DIV_W 8
`define SMM_A_CMD 32'h00000000
`define SMM_A_RESP 32'h00000004
`define SMM_A_STAT 32'h00000008
`define SMM_A_ISTAT 32'h0000000C
`define SMM_A_IMASK 32'h00000010
`define SMM_IRQ_DONE 0
`define SMM_IRQ_PERR 1
`define SMM_IRQ_W 2
`endif

// ==== smm_pkg.sv ====
`include "smm_defines.svh"
package smm_pkg;
  typedef enum logic [1:0] {
    SMM_KIND_NONE = 2'b00,
    SMM_KIND_MON2 = 2'b01,
    SMM_KIND_MON3 = 2'b10
  } smm_kind_t;

  typedef enum logic [2:0] {
    SMM_IDLE = 3'b000,
    SMM_LEAD = 3'b001,
    SMM_HIGH = 3'b010,
    SMM_LOW = 3'b011,
    SMM_TAIL = 3'b100,
    SMM_GAP = 3'b101
  } smm_fsm_t;

  typedef struct packed {
    logic sclk_q;
    logic cs_q;
    logic [`SMM_W-1:0] shin;
    logic [`SMM_W-1:0] shout;
    logic [4:0] bitcnt;
    logic miso;
    smm_kind_t kind;
    logic [2:0] chan;
    logic type_sel;
    logic por_flag;
    logic [`SMM_NCHAN-1:0] cur_prev;
    logic [`SMM_NCHAN-1:0][`SMM_DUR_W-1:0] dur;
    logic [`SMM_TICK_W-1:0] tick;
    logic [`SMM_NGATE-1:0] gin_q;
    logic [`SMM_NGATE-1:0][`SMM_HI_W-1:0] hi_cnt;
    logic [`SMM_NGATE-1:0][`SMM_LATCH_W-1:0] latch;
    logic [`SMM_NGATE-1:0] gate;
  } smm_dev_t;

  typedef struct packed {
    smm_fsm_t fsm;
    logic [`SMM_DIV_W-1:0] div;
    logic [3:0] bitcnt;
    logic [`SMM_W-1:0] tx;
    logic [`SMM_W-1:0] rx;
    logic [`SMM_W-1:0] cmd;
    logic [`SMM_W-1:0] resp;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [`SMM_IRQ_W-1:0] istat;
    logic [`SMM_IRQ_W-1:0] imask;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
  } smm_host_t;
endpackage : smm_pkg

// ==== smm_spi_if.sv ====
`timescale 1ns/1ps
interface smm_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev (input sclk, input cs_n, input mosi, output miso);
  modport ctl (output sclk, output cs_n, output mosi, input miso);
endinterface : smm_spi_if

// ==== smm_host.sv ====
`timescale 1ns/1ps
`include "smm_defines.svh"
module smm_host #(
  parameter int HALF_CYC = `SMM_HALF_DEF
) (
  input logic CORE_CLK,
  input logic SYS_RST,
  input logic PSEL,
  input logic PENABLE,
  input logic PWRITE,
  input logic [31:0] PADDR,
  input logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  smm_spi_if.ctl spi
);
  localparam logic [`SMM_DIV_W-1:0] HALF_LAST = `SMM_DIV_W'(HALF_CYC - 1);

  smm_pkg::smm_host_t s_r;
  smm_pkg::smm_host_t s_nxt;
  logic [31:0] rdata;
  logic hit;
  logic half_done;
  logic wr_cmd;
  logic [`SMM_W-1:0] word;
  logic [`SMM_IRQ_W-1:0] w1c;
  logic [`SMM_IRQ_W-1:0] set;

  always_comb begin
    s_nxt = s_r;
    rdata = 32'h00000000;
    hit = 1'b1;
    wr_cmd = 1'b0;
    w1c = '0;
    set = '0;
    word = PWDATA[`SMM_W-1:0];
    word[`SMM_PAR_BIT] = 1'b0;
    word[`SMM_PAR_BIT] = ~^word;
    half_done = (s_r.div == HALF_LAST);

    case (PADDR)
      `SMM_A_CMD: rdata = {16'h0000, s_r.cmd};
      `SMM_A_RESP: rdata = {16'h0000, s_r.resp};
      `SMM_A_STAT: rdata = {30'h00000000, ^s_r.resp, s_r.fsm != smm_pkg::SMM_IDLE};
      `SMM_A_ISTAT: rdata = {30'h00000000, s_r.istat};
      `SMM_A_IMASK: rdata = {30'h00000000, s_r.imask};
      default: hit = 1'b0;
    endcase

    // APB slave with one wait state
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    if (PSEL && PENABLE && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = ~hit;
      s_nxt.prdata = rdata;
    end else if (PSEL && PENABLE && PWRITE && s_r.pready) begin
      case (PADDR)
        `SMM_A_CMD: wr_cmd = (s_r.fsm == smm_pkg::SMM_IDLE);
        `SMM_A_ISTAT: w1c = PWDATA[`SMM_IRQ_W-1:0];
        `SMM_A_IMASK: s_nxt.imask = PWDATA[`SMM_IRQ_W-1:0];
        default: ;
      endcase
    end

    // Frame sequencer, SCLK idle low
    if (s_r.fsm != smm_pkg::SMM_IDLE) begin
      s_nxt.div = half_done ? '0 : s_r.div + `SMM_DIV_W'(1);
    end
    case (s_r.fsm)
      smm_pkg::SMM_IDLE: begin
        if (wr_cmd) begin
          s_nxt.cmd = word;
          s_nxt.tx = word;
          s_nxt.mosi = word[`SMM_W-1];
          s_nxt.cs_n = 1'b0;
          s_nxt.div = '0;
          s_nxt.bitcnt = '0;
          s_nxt.fsm = smm_pkg::SMM_LEAD;
        end
      end
      smm_pkg::SMM_LEAD, smm_pkg::SMM_LOW: begin
        if (half_done) begin
          s_nxt.sclk = 1'b1;
          s_nxt.rx = {s_r.rx[`SMM_W-2:0], spi.miso};
          s_nxt.fsm = smm_pkg::SMM_HIGH;
        end
      end
      smm_pkg::SMM_HIGH: begin
        if (half_done) begin
          s_nxt.sclk = 1'b0;
          if (s_r.bitcnt == 4'hF) begin
            s_nxt.fsm = smm_pkg::SMM_TAIL;
          end else begin
            s_nxt.bitcnt = s_r.bitcnt + 4'h1;
            s_nxt.tx = {s_r.tx[`SMM_W-2:0], 1'b0};
            s_nxt.mosi = s_r.tx[`SMM_W-2];
            s_nxt.fsm = smm_pkg::SMM_LOW;
          end
        end
      end
      smm_pkg::SMM_TAIL: begin
        if (half_done) begin
          s_nxt.cs_n = 1'b1;
          s_nxt.mosi = 1'b0;
          s_nxt.resp = s_r.rx;
          set[`SMM_IRQ_DONE] = 1'b1;
          set[`SMM_IRQ_PERR] = ~^s_r.rx;
          s_nxt.fsm = smm_pkg::SMM_GAP;
        end
      end
      smm_pkg::SMM_GAP: begin
        if (half_done) begin
          s_nxt.fsm = smm_pkg::SMM_IDLE;
        end
      end
      default: s_nxt.fsm = smm_pkg::SMM_IDLE;
    endcase

    // Sticky events, set wins over clear
    s_nxt.istat = (s_r.istat & ~w1c) | set;
    s_nxt.irq = |(s_nxt.istat & s_nxt.imask);
  end

  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      s_r <= '0;
      s_r.cs_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA = s_r.prdata;
  assign PREADY = s_r.pready;
  assign PSLVERR = s_r.pslverr;
  assign IRQ = s_r.irq;
  assign spi.sclk = s_r.sclk;
  assign spi.cs_n = s_r.cs_n;
  assign spi.mosi = s_r.mosi;
endmodule : smm_host

// ==== smm_checker.sv ====
`timescale 1ns/1ps
module smm_checker #(
  parameter int HALF_CYC = 5
) (
  input logic CORE_CLK,
  input logic SYS_RST,
  input logic sclk,
  input logic cs_n,
  input logic mosi,
  input logic miso
);
  logic sq_r, cq_r, fe;
  logic [15:0] mo_r, mi_r;
  logic [4:0] nb_r;
  logic [2:0] lc_r;
  logic [7:0] gap_r;
  assign fe = cs_n && !cq_r;
  // Shadow of each frame on the wire
  always_ff @(posedge CORE_CLK) begin
    if (SYS_RST) begin
      sq_r <= 1'b0;
      cq_r <= 1'b1;
      nb_r <= 5'h00;
      lc_r <= 3'h0;
      gap_r <= 8'hFF;
    end else begin
      sq_r <= sclk;
      cq_r <= cs_n;
      gap_r <= !cs_n ? 8'h00 : (gap_r == 8'hFF ? gap_r : gap_r + 8'h01);
      if (!cs_n && cq_r) begin
        nb_r <= 5'h00;
      end else if (sclk && !sq_r) begin
        nb_r <= nb_r + 5'h01;
        mo_r <= {mo_r[14:0], mosi};
        mi_r <= {mi_r[14:0], miso};
      end
      if (fe && (mo_r & 16'hCC00) == 16'hC400) begin
        lc_r <= mo_r[9:7];
      end
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_end;
    fe;
  endsequence
  sequence s_m2;
    s_end ##0 ((mi_r & 16'hCC00) == 16'hC400);
  endsequence
  property p_hold(logic v);
    !cs_n && sclk && $past(sclk) |-> $stable(v);
  endproperty
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("sclk moved outside frame");
  AST_FRAME_BITS: assert property (s_end |-> nb_r == 5'h10)
    else $error("frame not 16 bits");
  AST_GAP: assert property ($fell(cs_n) |-> gap_r >= HALF_CYC)
    else $error("frame gap short");
  AST_CMD_PARITY: assert property (s_end |-> ^mo_r)
    else $error("command parity even");
  AST_RESP_PARITY: assert property (s_end |-> mi_r == 16'h0000 || ^mi_r)
    else $error("response parity even");
  AST_RESP_HDR: assert property (fe && mi_r[15] |->
    mi_r[14] && !mi_r[12] && (mi_r[11] ^ mi_r[10])) else $error("bad header");
  AST_M2_CHAN: assert property (s_m2 |-> mi_r[9:7] == lc_r)
    else $error("channel echo wrong");
  AST_M3_GATE: assert property (fe && (mi_r & 16'hDE00) == 16'hCA00
    |-> mi_r[7:4] == 4'h0) else $error("gate upper bits set");
  AST_MOSI_HOLD: assert property (p_hold(mosi))
    else $error("mosi moved while sclk high");
  AST_MISO_HOLD: assert property (p_hold(miso))
    else $error("miso moved while sclk high");
endmodule : smm_checker

// ==== spi_monitor_mode_two_three_bench.sv ====
`timescale 1ns/1ps
`include "smm_defines.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module spi_monitor_mode_two_three_bench;
  logic clk, rst, psel, pen, pwr, pready, pslverr, irq, er;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] cur;
  logic [3:0] fgi, fg;
  logic [15:0] r;
  int err_count, num_checks;
  smm_spi_if u_smm_spi_if();
  smm_host #(.HALF_CYC(5)) u_smm_host (.CORE_CLK(clk), .SYS_RST(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .spi(u_smm_spi_if.ctl));
  smm_device #(.LATCH_UNIT_CYC(50)) u_smm_device (.CORE_CLK(clk), .SYS_RST(rst),
    .spi(u_smm_spi_if.dev), .CURRENT_FLAG(cur), .FIRE_GATE_INPUT(fgi),
    .LATCH_SEL(8'h0C), .FIRE_GATE(fg));
  smm_checker #(.HALF_CYC(5)) u_smm_checker (.CORE_CLK(clk), .SYS_RST(rst),
    .sclk(u_smm_spi_if.sclk), .cs_n(u_smm_spi_if.cs_n), .mosi(u_smm_spi_if.mosi),
    .miso(u_smm_spi_if.miso));
  function automatic logic [15:0] par(input logic [15:0] w);
    par = w & 16'hDFFF;
    par[13] = ~^par;
  endfunction : par
  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic frm(input logic [15:0] c);
    int i;
    apb(1'b1, `SMM_A_CMD, {16'h0000, c});
    for (i = 0; i < 1000 && irq !== 1'b1; i++) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b0, `SMM_A_RESP, 32'h0);
    r = rd[15:0];
    apb(1'b1, `SMM_A_ISTAT, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
  endtask : frm
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1000000;
    err_count++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    cur = 8'h00;
    fgi = 4'h5;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, `SMM_A_IMASK, 32'h1);
    apb(1'b0, 32'h00000020, 32'h0);
    `CHK(er, 1'b1)
    `CHK(rd, 32'h0)
    frm(16'hC800);
    `CHK(r, par(16'h0000))
    cur <= 8'hA5;
    frm(16'hCA00);
    `CHK(r, par(16'hC8A5))
    cur <= 8'h00;
    frm(16'hC580);
    `CHK(r, par(16'hCB05))
    cur <= 8'h08;
    repeat (5625) @(posedge clk);
    cur <= 8'h00;
    frm(16'hD580);
    `CHK(r & 16'hDF80, 16'hC580)
    `CHK(r[6:0] >= 7'h04 && r[6:0] <= 7'h05, 1'b1)
    `CHK(^r, 1'b1)
    frm(16'hC680);
    `CHK(r, par(16'hC580))
    frm(16'hC680);
    `CHK(r, par(16'hC680))
    apb(1'b0, `SMM_A_CMD, 32'h0);
    `CHK(rd, 32'(par(16'hC680)))
    apb(1'b0, `SMM_A_STAT, 32'h0);
    `CHK(rd, 32'h00000002)
    `CHK(fg, 4'h5)
    fgi <= 4'h7;
    repeat (900) @(posedge clk);
    fgi <= 4'h5;
    repeat (20) @(posedge clk);
    `CHK(fg, 4'h7)
    repeat (250) @(posedge clk);
    `CHK(fg, 4'h5)
    fgi <= 4'h7;
    repeat (100) @(posedge clk);
    fgi <= 4'h5;
    repeat (5) @(posedge clk);
    `CHK(fg, 4'h5)
    apb(1'b1, `SMM_A_IMASK, 32'h0);
    apb(1'b1, `SMM_A_CMD, 32'h0000C800);
    apb(1'b0, `SMM_A_STAT, 32'h0);
    `CHK(rd, 32'h00000003)
    apb(1'b1, `SMM_A_CMD, 32'h0000C580);
    apb(1'b0, `SMM_A_CMD, 32'h0);
    `CHK(rd, 32'(par(16'hC800)))
    repeat (400) @(posedge clk);
    `CHK(irq, 1'b0)
    apb(1'b1, `SMM_A_IMASK, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, `SMM_A_ISTAT, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b1, `SMM_A_IMASK, 32'h1);
    frm(16'hC800);
    `CHK(r, par(16'h0000))
    frm(16'hC800);
    `CHK(r, par(16'hC800))
    end_sim();
  end
endmodule : spi_monitor_mode_two_three_bench
